// file: verilog/rpsc_pkg.sv
// Purpose: constants and types for the protocol subset configuration block
// Assumes: 8-bit register port, one access per mclk cycle
// Notes: the timer high byte is stored and read back only
//
// Contract
// - codes 0-3: vicinity single subcarrier, rate/coding bits
// - codes 4-7: vicinity double subcarrier, same bits
// - default protocol code is 2
// - codes 8-11: type A receive 106-848 kbps
// - codes 12-15: type B receive 106-848 kbps
// - split enable: prox transmit uses programmed rate
// - transmit rate field 00..11 means 106..848
// - tx alt parity: odd, last byte even
// - rx alt parity: odd, last byte even
// - three-bit guard: 0-7 etu between characters
// - guard-after-last clear: omit guard after final byte
// - eof low 11 etu if set, else 10
// - sof high 3 etu if set, else 2
// - sof low 11 etu if set, else 10
// - type B options reset to zero
// - type A options reset, cleared on protocol write
// - timer high byte 0xc2 at reset, protocol write
// - protocol code bits 4:0, reset 0x02
package rpsc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] RPSC_ADDR_PROTO = 5'h01;
  localparam logic [4:0] RPSC_ADDR_TXB = 5'h02;
  localparam logic [4:0] RPSC_ADDR_RATE = 5'h03;
  localparam logic [4:0] RPSC_ADDR_TIMER = 5'h04;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RPSC_RST_PROTO = 8'h02;
  localparam logic [7:0] RPSC_RST_TXB = 8'h00;
  localparam logic [7:0] RPSC_RST_RATE = 8'h00;
  localparam logic [7:0] RPSC_RST_TIMER = 8'hc2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RPSC_CODE_MSB = 4;
  localparam int RPSC_GUARD_MSB = 7;
  localparam int RPSC_GUARD_LSB = 5;
  localparam int RPSC_EOF_LOW_BIT = 4;
  localparam int RPSC_SOF_HIGH_BIT = 3;
  localparam int RPSC_SOF_LOW_BIT = 2;
  localparam int RPSC_GUARD_LAST_BIT = 1;
  localparam int RPSC_SPLIT_BIT = 7;
  localparam int RPSC_TXRATE_MSB = 6;
  localparam int RPSC_TXRATE_LSB = 5;
  localparam int RPSC_TXPAR_BIT = 4;
  localparam int RPSC_RXPAR_BIT = 3;
  localparam logic [7:0] RPSC_TXB_MASK = 8'hfe;
  localparam logic [7:0] RPSC_RATE_MASK = 8'hf8;

  // ----------------------------------------------------------------
  // frame lengths in etu
  // ----------------------------------------------------------------
  localparam logic [3:0] RPSC_EOF_LOW_LONG = 4'hb;
  localparam logic [3:0] RPSC_EOF_LOW_SHORT = 4'ha;
  localparam logic [1:0] RPSC_SOF_HIGH_LONG = 2'h3;
  localparam logic [1:0] RPSC_SOF_HIGH_SHORT = 2'h2;
  localparam logic [3:0] RPSC_SOF_LOW_LONG = 4'hb;
  localparam logic [3:0] RPSC_SOF_LOW_SHORT = 4'ha;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RPSC_FAM_VIC = 2'h0,
    RPSC_FAM_PROX_A = 2'h1,
    RPSC_FAM_PROX_B = 2'h3,
    RPSC_FAM_RSVD = 2'h2
  } rpsc_family_t;

  // bit rate code: 0=106, 1=212, 2=424, 3=848 kbps
  typedef logic [1:0] rpsc_rate_t;

endpackage

// file: verilog/rpsc_decode.sv
// Purpose: decode the five-bit protocol code into framing selections
// Assumes: purely combinational, registered by the caller
// Notes: undefined codes map to the reserved family with zero fields

// --------------------------------------------------------------------
// protocol code decoder
// --------------------------------------------------------------------
module rpsc_decode (
  input wire logic [4:0] code,
  output rpsc_pkg::rpsc_family_t family,
  output logic dual_sub,
  output logic vic_high,
  output logic vic_c256,
  output rpsc_pkg::rpsc_rate_t rx_rate
);

  logic is_vic;
  logic is_prox;

  assign is_vic = (code[4:3] == 2'h0);
  assign is_prox = (code[4:3] == 2'h1);

  assign family = is_vic ? rpsc_pkg::RPSC_FAM_VIC :
                  !is_prox ? rpsc_pkg::RPSC_FAM_RSVD :
                  code[2] ? rpsc_pkg::RPSC_FAM_PROX_B : rpsc_pkg::RPSC_FAM_PROX_A;

  assign dual_sub = is_vic & code[2];
  assign vic_high = is_vic & code[1];
  assign vic_c256 = is_vic & code[0];
  assign rx_rate = is_prox ? code[1:0] : 2'h0;

endmodule // rpsc_decode

// file: verilog/rpsc_top.sv
// Purpose: protocol selection and subset registers for the framer
// Assumes: register port driven by logic on mclk; chip_en is a pin
// Notes: decoded outputs lag the registers by one cycle

// --------------------------------------------------------------------
// configuration registers and decoded framing controls
// --------------------------------------------------------------------
module rpsc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic chip_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic tx_last_byte,
  input wire logic rx_last_byte,
  output logic [7:0] reg_rdata_ff,
  output rpsc_pkg::rpsc_family_t family_ff,
  output logic dual_sub_ff,
  output logic vic_high_ff,
  output logic vic_c256_ff,
  output rpsc_pkg::rpsc_rate_t rx_rate_ff,
  output rpsc_pkg::rpsc_rate_t tx_rate_ff,
  output logic tx_parity_odd_ff,
  output logic rx_parity_odd_ff,
  output logic [2:0] tx_guard_etu_ff,
  output logic [3:0] eof_low_etu_ff,
  output logic [1:0] sof_high_etu_ff,
  output logic [3:0] sof_low_etu_ff
);

  // ------------------------------------------------------------------
  // chip enable synchroniser
  // ------------------------------------------------------------------
  logic en_meta_ff;
  logic en_sync_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en_meta_ff <= 1'b0;
      en_sync_ff <= 1'b0;
    end else begin
      en_meta_ff <= chip_en;
      en_sync_ff <= en_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // register write decode
  // ------------------------------------------------------------------
  logic [7:0] proto_ff;
  logic [7:0] txb_ff;
  logic [7:0] rate_ff;
  logic [7:0] timer_ff;
  logic [7:0] nxt_proto;
  logic [7:0] nxt_txb;
  logic [7:0] nxt_rate;
  logic [7:0] nxt_timer;
  logic wr_proto;
  logic wr_txb;
  logic wr_rate;
  logic wr_timer;

  assign wr_proto = reg_wr & (reg_addr == rpsc_pkg::RPSC_ADDR_PROTO);
  assign wr_txb = reg_wr & (reg_addr == rpsc_pkg::RPSC_ADDR_TXB);
  assign wr_rate = reg_wr & (reg_addr == rpsc_pkg::RPSC_ADDR_RATE);
  assign wr_timer = reg_wr & (reg_addr == rpsc_pkg::RPSC_ADDR_TIMER);

  // protocol register, reset on chip enable low
  assign nxt_proto = !en_sync_ff ? rpsc_pkg::RPSC_RST_PROTO :
                     wr_proto ? reg_wdata : proto_ff;
  // type B options reset on chip enable low
  assign nxt_txb = !en_sync_ff ? rpsc_pkg::RPSC_RST_TXB :
                   wr_txb ? (reg_wdata & rpsc_pkg::RPSC_TXB_MASK) : txb_ff;
  // type A options cleared by protocol write
  assign nxt_rate = (!en_sync_ff || wr_proto) ? rpsc_pkg::RPSC_RST_RATE :
                    wr_rate ? (reg_wdata & rpsc_pkg::RPSC_RATE_MASK) : rate_ff;
  // timer high byte reloaded by protocol write
  assign nxt_timer = (!en_sync_ff || wr_proto) ? rpsc_pkg::RPSC_RST_TIMER :
                     wr_timer ? reg_wdata : timer_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      proto_ff <= rpsc_pkg::RPSC_RST_PROTO;
      txb_ff <= rpsc_pkg::RPSC_RST_TXB;
      rate_ff <= rpsc_pkg::RPSC_RST_RATE;
      timer_ff <= rpsc_pkg::RPSC_RST_TIMER;
    end else begin
      proto_ff <= nxt_proto;
      txb_ff <= nxt_txb;
      rate_ff <= nxt_rate;
      timer_ff <= nxt_timer;
    end
  end

  // ------------------------------------------------------------------
  // read back
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] nxt_rdata;

  assign rd_mux = (reg_addr == rpsc_pkg::RPSC_ADDR_PROTO) ? proto_ff :
                  (reg_addr == rpsc_pkg::RPSC_ADDR_TXB) ? txb_ff :
                  (reg_addr == rpsc_pkg::RPSC_ADDR_RATE) ? rate_ff :
                  (reg_addr == rpsc_pkg::RPSC_ADDR_TIMER) ? timer_ff : 8'h00;
  assign nxt_rdata = reg_rd ? rd_mux : reg_rdata_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------------
  // protocol decode
  // ------------------------------------------------------------------
  rpsc_pkg::rpsc_family_t dec_family;
  logic dec_dual;
  logic dec_high;
  logic dec_c256;
  rpsc_pkg::rpsc_rate_t dec_rx_rate;

  rpsc_decode u_decode (
    .code(proto_ff[rpsc_pkg::RPSC_CODE_MSB:0]),
    .family(dec_family),
    .dual_sub(dec_dual),
    .vic_high(dec_high),
    .vic_c256(dec_c256),
    .rx_rate(dec_rx_rate)
  );

  // ------------------------------------------------------------------
  // transmit selections
  // ------------------------------------------------------------------
  logic is_a;
  logic is_b;
  logic split_en;
  rpsc_pkg::rpsc_rate_t field_tx_rate;
  rpsc_pkg::rpsc_rate_t nxt_tx_rate;
  logic nxt_tx_odd;
  logic nxt_rx_odd;
  logic [2:0] guard_field;
  logic [2:0] nxt_guard;
  logic [3:0] nxt_eof_low;
  logic [1:0] nxt_sof_high;
  logic [3:0] nxt_sof_low;

  assign is_a = (dec_family == rpsc_pkg::RPSC_FAM_PROX_A);
  assign is_b = (dec_family == rpsc_pkg::RPSC_FAM_PROX_B);
  assign split_en = rate_ff[rpsc_pkg::RPSC_SPLIT_BIT];
  assign field_tx_rate = rate_ff[rpsc_pkg::RPSC_TXRATE_MSB:rpsc_pkg::RPSC_TXRATE_LSB];
  assign nxt_tx_rate = (split_en && (is_a || is_b)) ? field_tx_rate : dec_rx_rate;
  // transmit parity, odd except last byte in type A alternate mode above 106 kbps
  assign nxt_tx_odd = !(is_a && (nxt_tx_rate != 2'h0) &&
                        rate_ff[rpsc_pkg::RPSC_TXPAR_BIT] && tx_last_byte);
  // receive parity check, odd except last byte in type A alternate mode above 106 kbps
  assign nxt_rx_odd = !(is_a && (dec_rx_rate != 2'h0) &&
                        rate_ff[rpsc_pkg::RPSC_RXPAR_BIT] && rx_last_byte);
  assign guard_field = txb_ff[rpsc_pkg::RPSC_GUARD_MSB:rpsc_pkg::RPSC_GUARD_LSB];
  assign nxt_guard = (!is_b || (tx_last_byte && !txb_ff[rpsc_pkg::RPSC_GUARD_LAST_BIT])) ?
                     3'h0 : guard_field;
  assign nxt_eof_low = txb_ff[rpsc_pkg::RPSC_EOF_LOW_BIT] ? rpsc_pkg::RPSC_EOF_LOW_LONG :
                       rpsc_pkg::RPSC_EOF_LOW_SHORT;
  assign nxt_sof_high = txb_ff[rpsc_pkg::RPSC_SOF_HIGH_BIT] ? rpsc_pkg::RPSC_SOF_HIGH_LONG :
                        rpsc_pkg::RPSC_SOF_HIGH_SHORT;
  assign nxt_sof_low = txb_ff[rpsc_pkg::RPSC_SOF_LOW_BIT] ? rpsc_pkg::RPSC_SOF_LOW_LONG :
                       rpsc_pkg::RPSC_SOF_LOW_SHORT;

  // ------------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      family_ff <= rpsc_pkg::RPSC_FAM_VIC;
      dual_sub_ff <= 1'b0;
      vic_high_ff <= 1'b1;
      vic_c256_ff <= 1'b0;
      rx_rate_ff <= 2'h0;
      tx_rate_ff <= 2'h0;
      tx_parity_odd_ff <= 1'b1;
      rx_parity_odd_ff <= 1'b1;
      tx_guard_etu_ff <= 3'h0;
      eof_low_etu_ff <= rpsc_pkg::RPSC_EOF_LOW_SHORT;
      sof_high_etu_ff <= rpsc_pkg::RPSC_SOF_HIGH_SHORT;
      sof_low_etu_ff <= rpsc_pkg::RPSC_SOF_LOW_SHORT;
    end else begin
      family_ff <= dec_family;
      dual_sub_ff <= dec_dual;
      vic_high_ff <= dec_high;
      vic_c256_ff <= dec_c256;
      rx_rate_ff <= dec_rx_rate;
      tx_rate_ff <= nxt_tx_rate;
      tx_parity_odd_ff <= nxt_tx_odd;
      rx_parity_odd_ff <= nxt_rx_odd;
      tx_guard_etu_ff <= nxt_guard;
      eof_low_etu_ff <= nxt_eof_low;
      sof_high_etu_ff <= nxt_sof_high;
      sof_low_etu_ff <= nxt_sof_low;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  chk_proto_reset_val: assert property (
    !en_sync_ff |=> (proto_ff == 8'h02))
    else $error("protocol register not 0x02 after enable low");

  chk_txb_reset_val: assert property (
    !en_sync_ff |=> (txb_ff == 8'h00))
    else $error("type B options not cleared by enable low");

  chk_rate_proto_clear: assert property (
    (en_sync_ff && wr_proto) |=> (rate_ff == 8'h00))
    else $error("type A options not cleared by protocol write");

  chk_timer_proto_reload: assert property (
    wr_proto |=> (timer_ff == 8'hc2))
    else $error("timer high byte not reloaded by protocol write");

  chk_vic_single_decode: assert property (
    (proto_ff[4:2] == 3'h0) |=> (family_ff == rpsc_pkg::RPSC_FAM_VIC) && !dual_sub_ff
      && (vic_high_ff == $past(proto_ff[1])) && (vic_c256_ff == $past(proto_ff[0])))
    else $error("single subcarrier decode wrong");

  chk_vic_dual_decode: assert property (
    (proto_ff[4:2] == 3'h1) |=> dual_sub_ff && (vic_high_ff == $past(proto_ff[1])))
    else $error("double subcarrier decode wrong");

  chk_prox_rx_rate: assert property (
    (proto_ff[4:3] == 2'h1) |=> (rx_rate_ff == $past(proto_ff[1:0]))
      && (family_ff[1] == $past(proto_ff[2])))
    else $error("proximity receive rate or family wrong");

  chk_split_tx_rate: assert property (
    (split_en && (proto_ff[4:3] == 2'h1)) |=> (tx_rate_ff == $past(rate_ff[6:5])))
    else $error("split transmit rate not applied");

  chk_sof_eof_len: assert property (
    ##1 (eof_low_etu_ff == ($past(txb_ff[4]) ? 4'hb : 4'ha))
      && (sof_high_etu_ff == ($past(txb_ff[3]) ? 2'h3 : 2'h2))
      && (sof_low_etu_ff == ($past(txb_ff[2]) ? 4'hb : 4'ha)))
    else $error("frame delimiter length wrong");

  chk_guard_last_omit: assert property (
    (is_b && tx_last_byte && !txb_ff[1]) |=> (tx_guard_etu_ff == 3'h0))
    else $error("guard not omitted after final byte");

  chk_tx_parity_last: assert property (
    (is_a && (nxt_tx_rate != 2'h0) && rate_ff[4]) |=> (tx_parity_odd_ff == !$past(tx_last_byte)))
    else $error("alternate transmit parity wrong");

  chk_default_decode: assert property (
    !en_sync_ff |-> ##2 ((family_ff == rpsc_pkg::RPSC_FAM_VIC) && vic_high_ff
      && !vic_c256_ff && !dual_sub_ff))
    else $error("default protocol decode wrong");

  chk_vic_dual_coding: assert property (
    (proto_ff[4:2] == 3'h1) |=> (family_ff == rpsc_pkg::RPSC_FAM_VIC)
      && (vic_c256_ff == $past(proto_ff[0])))
    else $error("double subcarrier coding wrong");

  chk_prox_a_decode: assert property (
    (proto_ff[4:2] == 3'h2) |=> (family_ff == rpsc_pkg::RPSC_FAM_PROX_A)
      && (rx_rate_ff == $past(proto_ff[1:0])))
    else $error("type A receive decode wrong");

  chk_prox_vic_idle: assert property (
    (proto_ff[4:3] == 2'h1) |=> !dual_sub_ff && !vic_high_ff && !vic_c256_ff)
    else $error("vicinity controls active for proximity code");

  chk_prox_b_decode: assert property (
    (proto_ff[4:2] == 3'h3) |=> (family_ff == rpsc_pkg::RPSC_FAM_PROX_B)
      && (rx_rate_ff == $past(proto_ff[1:0])))
    else $error("type B receive decode wrong");

  chk_tx_rate_follow: assert property (
    (!split_en || (proto_ff[4:3] != 2'h1)) |=> (tx_rate_ff == rx_rate_ff))
    else $error("transmit rate differs without split enable");

  chk_rate_field_load: assert property (
    (en_sync_ff && wr_rate) |=> (rate_ff[6:5] == $past(reg_wdata[6:5])))
    else $error("transmit rate field not stored");

  chk_tx_parity_plain: assert property (
    (!rate_ff[4] || (nxt_tx_rate == 2'h0)) |=> tx_parity_odd_ff)
    else $error("transmit parity not odd without alternate mode");

  chk_rx_parity_last: assert property (
    (is_a && (dec_rx_rate != 2'h0) && rate_ff[3]) |=> (rx_parity_odd_ff == !$past(rx_last_byte)))
    else $error("alternate receive parity wrong");

  chk_rx_parity_plain: assert property (
    !rate_ff[3] |=> rx_parity_odd_ff)
    else $error("receive parity not odd without alternate mode");

  chk_guard_count: assert property (
    (is_b && !tx_last_byte) |=> (tx_guard_etu_ff == $past(txb_ff[7:5])))
    else $error("guard count not applied between characters");

  chk_guard_not_b: assert property (
    !is_b |=> (tx_guard_etu_ff == 3'h0))
    else $error("guard count outside type B");

  chk_guard_each_byte: assert property (
    (is_b && txb_ff[1]) |=> (tx_guard_etu_ff == $past(txb_ff[7:5])))
    else $error("guard not kept after final byte");

  chk_eof_low_long: assert property (
    txb_ff[4] |=> (eof_low_etu_ff == 4'hb))
    else $error("long end of frame low wrong");

  chk_sof_high_long: assert property (
    txb_ff[3] |=> (sof_high_etu_ff == 2'h3))
    else $error("long start of frame high wrong");

  chk_sof_low_long: assert property (
    txb_ff[2] |=> (sof_low_etu_ff == 4'hb))
    else $error("long start of frame low wrong");

  chk_rate_reset_val: assert property (
    !en_sync_ff |=> (rate_ff == 8'h00))
    else $error("type A options not cleared by enable low");

  chk_timer_reset_val: assert property (
    !en_sync_ff |=> (timer_ff == 8'hc2))
    else $error("timer high byte not reloaded by enable low");

  chk_proto_write_load: assert property (
    (en_sync_ff && wr_proto) |=> (proto_ff == $past(reg_wdata)))
    else $error("protocol register not loaded by write");

  // ------------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------------
  cov_proto_write: cover property (wr_proto ##1 (timer_ff == 8'hc2));
  cov_type_b_guard: cover property (is_b && (tx_guard_etu_ff == 3'h7));
  cov_split_rate: cover property (split_en && is_a && (tx_rate_ff != rx_rate_ff));
  cov_enable_return: cover property (!en_sync_ff ##1 en_sync_ff);

endmodule // rpsc_top

// file: bench/rpsc_host_model.sv
// Purpose: host controller model driving the configuration register port
// Assumes: requests launched on the falling edge of mclk
// Notes: released address and data lines show the inverse of the last value

// ----------------------------------------------------------------
// host model
// ----------------------------------------------------------------
module rpsc_host_model (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end

  // any address and data are written as given; protocol codes are not checked
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_ff;
  endtask
endmodule // rpsc_host_model

// file: bench/tb.sv
// Purpose: self-checking bench for the protocol subset configuration block
// Assumes: host model drives the register port, bench drives pins
// Notes: outputs are checked two cycles after their cause

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic chip_en = 1'b1;
  logic tx_last_byte = 1'b0;
  logic rx_last_byte = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_ff;
  rpsc_pkg::rpsc_family_t family_ff;
  logic dual_sub_ff;
  logic vic_high_ff;
  logic vic_c256_ff;
  rpsc_pkg::rpsc_rate_t rx_rate_ff;
  rpsc_pkg::rpsc_rate_t tx_rate_ff;
  logic tx_parity_odd_ff;
  logic rx_parity_odd_ff;
  logic [2:0] tx_guard_etu_ff;
  logic [3:0] eof_low_etu_ff;
  logic [1:0] sof_high_etu_ff;
  logic [3:0] sof_low_etu_ff;
  logic [7:0] b;
  logic [7:0] txb_tab [5] = '{8'he0, 8'h62, 8'h1c, 8'h14, 8'h08};
  int fails = 0;
  int check_count = 0;

  always #25 mclk = ~mclk;

  rpsc_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));

  rpsc_top dut (.mclk(mclk), .arst_n(arst_n), .chip_en(chip_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .tx_last_byte(tx_last_byte), .rx_last_byte(rx_last_byte),
    .reg_rdata_ff(reg_rdata_ff), .family_ff(family_ff), .dual_sub_ff(dual_sub_ff),
    .vic_high_ff(vic_high_ff), .vic_c256_ff(vic_c256_ff), .rx_rate_ff(rx_rate_ff),
    .tx_rate_ff(tx_rate_ff), .tx_parity_odd_ff(tx_parity_odd_ff),
    .rx_parity_odd_ff(rx_parity_odd_ff), .tx_guard_etu_ff(tx_guard_etu_ff),
    .eof_low_etu_ff(eof_low_etu_ff), .sof_high_etu_ff(sof_high_etu_ff),
    .sof_low_etu_ff(sof_low_etu_ff));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk("register read", exp, v);
  endtask

  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask

  task automatic dchk(input logic [4:0] c);
    logic vic;
    vic = (c < 5'h08);
    chk("family", {6'h0, vic ? 2'h0 : (c[2] ? 2'h3 : 2'h1)}, {6'h0, family_ff});
    chk("rx rate", {6'h0, vic ? 2'h0 : c[1:0]}, {6'h0, rx_rate_ff});
    if (vic) begin
      chk("double subcarrier", {7'h0, c[2]}, {7'h0, dual_sub_ff});
      chk("vicinity rate", {7'h0, c[1]}, {7'h0, vic_high_ff});
      chk("vicinity coding", {7'h0, c[0]}, {7'h0, vic_c256_ff});
    end
  endtask

  task automatic regs_at_reset;
    rchk(5'h01, 8'h02);
    rchk(5'h02, 8'h00);
    rchk(5'h03, 8'h00);
    rchk(5'h04, 8'hc2);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("FAIL watchdog expected end seen running");
    final_report();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    regs_at_reset();
    rchk(5'h1f, 8'h00);
    dchk(5'h02);
    chk("sof high", 8'h02, {6'h0, sof_high_etu_ff});
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      host.wr(5'h01, 8'(c));
      settle();
      dchk(5'(c));
      rchk(5'h01, 8'(c));
    end
    $display("test protocol codes done");
    host.wr(5'h01, 8'h0c);
    for (int i = 0; i < 5; i++) begin
      b = txb_tab[i];
      host.wr(5'h02, b);
      for (int l = 0; l < 2; l++) begin
        tx_last_byte = l[0];
        settle();
        chk("guard", {5'h0, (l == 1 && !b[1]) ? 3'h0 : b[7:5]}, {5'h0, tx_guard_etu_ff});
        chk("eof low", b[4] ? 8'h0b : 8'h0a, {4'h0, eof_low_etu_ff});
        chk("sof high", b[3] ? 8'h03 : 8'h02, {6'h0, sof_high_etu_ff});
        chk("sof low", b[2] ? 8'h0b : 8'h0a, {4'h0, sof_low_etu_ff});
      end
      rchk(5'h02, b & 8'hfe);
    end
    host.wr(5'h03, 8'he0);
    settle();
    chk("tx rate", 8'h03, {6'h0, tx_rate_ff});
    tx_last_byte = 1'b0;
    $display("test type b options done");
    host.wr(5'h01, 8'h09);
    for (int r = 0; r < 4; r++) begin
      host.wr(5'h03, {1'b1, r[1:0], 5'h00});
      settle();
      chk("tx rate", 8'(r), {6'h0, tx_rate_ff});
    end
    host.wr(5'h03, 8'h18);
    for (int l = 0; l < 2; l++) begin
      tx_last_byte = l[0];
      rx_last_byte = l[0];
      settle();
      chk("tx parity", {7'h0, ~l[0]}, {7'h0, tx_parity_odd_ff});
      chk("rx parity", {7'h0, ~l[0]}, {7'h0, rx_parity_odd_ff});
    end
    host.wr(5'h03, 8'h10);
    settle();
    chk("tx parity", 8'h00, {7'h0, tx_parity_odd_ff});
    chk("rx parity", 8'h01, {7'h0, rx_parity_odd_ff});
    host.wr(5'h03, 8'h08);
    settle();
    chk("tx parity", 8'h01, {7'h0, tx_parity_odd_ff});
    chk("rx parity", 8'h00, {7'h0, rx_parity_odd_ff});
    chk("tx rate", 8'h01, {6'h0, tx_rate_ff});
    host.wr(5'h01, 8'h08);
    host.wr(5'h03, 8'h18);
    settle();
    chk("tx parity", 8'h01, {7'h0, tx_parity_odd_ff});
    chk("rx parity", 8'h01, {7'h0, rx_parity_odd_ff});
    tx_last_byte = 1'b0;
    rx_last_byte = 1'b0;
    $display("test type a options done");
    host.wr(5'h04, 8'h55);
    host.wr(5'h03, 8'hbf);
    rchk(5'h04, 8'h55);
    rchk(5'h03, 8'hb8);
    host.wr(5'h01, 8'h0d);
    rchk(5'h03, 8'h00);
    rchk(5'h04, 8'hc2);
    $display("test protocol write side effects done");
    host.wr(5'h02, 8'hfe);
    host.wr(5'h04, 8'h11);
    chip_en = 1'b0;
    repeat (4) @(negedge mclk);
    host.wr(5'h02, 8'he0);
    rchk(5'h02, 8'h00);
    rchk(5'h04, 8'hc2);
    chip_en = 1'b1;
    repeat (3) @(negedge mclk);
    regs_at_reset();
    host.wr(5'h01, 8'h0f);
    host.wr(5'h04, 8'h33);
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    regs_at_reset();
    $display("test chip enable and reset done");
    final_report();
  end
endmodule // tb
